// [core/fcc_pkg.sv]
package fcc_pkg;

    localparam int unsigned ADDR_W = 16;
    localparam int unsigned REG_AW = 4;
    localparam int unsigned IRQ_N = 3;

    ////////////////////////////////////////////////////////////////////////////////
    localparam logic [7:0] CMD_BLANK = 8'h05;
    localparam logic [7:0] CMD_PROG = 8'h20;
    localparam logic [7:0] CMD_BURST = 8'h25;
    localparam logic [7:0] CMD_PAGE = 8'h40;
    localparam logic [7:0] CMD_MASS = 8'h41;

    ////////////////////////////////////////////////////////////////////////////////
    localparam logic [3:0] REG_CONFIG = 4'h0;
    localparam logic [3:0] REG_PROTECT = 4'h1;
    localparam logic [3:0] REG_STATUS = 4'h2;
    localparam logic [3:0] REG_COMMAND = 4'h3;
    localparam logic [3:0] REG_ADDR = 4'h4;
    localparam logic [3:0] REG_DATA = 4'h5;
    localparam logic [3:0] REG_DIVIDER = 4'h6;
    localparam logic [3:0] REG_INT_STAT = 4'h7;
    localparam logic [3:0] REG_INT_CLR = 4'h8;
    localparam logic [3:0] REG_INT_EN = 4'h9;
    localparam logic [3:0] REG_SECURITY = 4'hA;

    localparam int unsigned CFG_KEY_BIT = 5;
    localparam int unsigned ST_CBEF = 7;
    localparam int unsigned ST_CCF = 6;
    localparam int unsigned ST_PVIOL = 5;
    localparam int unsigned ST_ACCERR = 4;
    localparam int unsigned ST_BLANK = 2;
    localparam int unsigned DIV_LOADED = 7;
    localparam int unsigned IRQ_CCF = 0;
    localparam int unsigned IRQ_PVIOL = 1;
    localparam int unsigned IRQ_ACCERR = 2;

    localparam logic [1:0] SEC_UNSECURED = 2'h2;
    localparam int unsigned ROW_LSB = 6;
    localparam int unsigned PAGE_LSB = 9;
    localparam int unsigned KEY_LSB = 3;
    localparam logic [15:0] KEY_BASE = 16'hFFB0;

    ////////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [7:0] cmd;
        logic [ADDR_W-1:0] addr;
        logic [7:0] data;
    } fcc_arr_req_t;

    typedef enum logic [1:0] {SEQ_IDLE, SEQ_DATA, SEQ_CMD} fcc_seq_t;
    typedef enum logic {ENG_IDLE, ENG_BUSY} fcc_eng_t;

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic cmd_legal(input logic [7:0] c);
        cmd_legal = (c == CMD_BLANK) || (c == CMD_PROG) || (c == CMD_BURST)
            || (c == CMD_PAGE) || (c == CMD_MASS);
    endfunction

    function automatic logic cmd_modifies(input logic [7:0] c);
        cmd_modifies = (c == CMD_PROG) || (c == CMD_BURST) || (c == CMD_PAGE) || (c == CMD_MASS);
    endfunction

    // A row boundary breaks pump retention even when the upper bits agree.
    function automatic logic same_row(input logic [15:0] a, input logic [15:0] b);
        same_row = (a[15:ROW_LSB] == b[15:ROW_LSB]) && (b[ROW_LSB-1:0] != '0);
    endfunction

    function automatic logic in_key_range(input logic [15:0] a);
        in_key_range = (a[15:KEY_LSB] == KEY_BASE[15:KEY_LSB]);
    endfunction

endpackage

// [core/fcc_prot.sv]
`timescale 1ns/100ps
module fcc_prot
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic [7:0] nv_copy,
    input wire logic wr,
    input wire logic [7:0] wdata,
    input wire logic [15:0] chk_addr,
    input wire logic chk_mass,
    output logic [7:0] prot_q,
    output logic hit
);
    import fcc_pkg::*;

    logic [7:0] prot_d;
    logic raise_ok;

    // Only a smaller select value is taken, so software can never loosen protection.
    assign raise_ok = wr && !prot_q[0] && (wdata[7:1] < prot_q[7:1]);
    assign prot_d = raise_ok ? {wdata[7:1], 1'b0} : prot_q;
    // The high end above the select boundary is protected; mass erase touches it always.
    assign hit = !prot_q[0] && (chk_mass || (chk_addr[15:PAGE_LSB] > prot_q[7:1]));

    always_ff @(posedge clk)
    begin
        if (!rstn)
            prot_q <= nv_copy;
        else
            prot_q <= prot_d;
    end

endmodule

// [core/fcc_irq.sv]
`timescale 1ns/100ps
module fcc_irq
#(
    parameter int unsigned N = 3
)
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic [N-1:0] set,
    input wire logic clr_wr,
    input wire logic en_wr,
    input wire logic [N-1:0] wdata,
    output logic [N-1:0] status_q,
    output logic [N-1:0] enable_q,
    output logic irq_q
);
    logic [N-1:0] status_d;
    logic [N-1:0] enable_d;

    // A new event in the clearing cycle survives the clear.
    assign status_d = set | (status_q & ~(clr_wr ? wdata : '0));
    assign enable_d = en_wr ? wdata : enable_q;

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            status_q <= '0;
            enable_q <= '0;
            irq_q <= 1'b0;
        end
        else
        begin
            status_q <= status_d;
            enable_q <= enable_d;
            irq_q <= |(status_d & enable_d);
        end
    end

endmodule

// [core/fcc_top.sv]
// Design decisions made here: the Avalon-MM slave port and the register offsets.
`timescale 1ns/100ps
module fcc_top
(
    input wire logic SYS_CLK,
    input wire logic RSTN,
    input wire logic [fcc_pkg::REG_AW-1:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    output fcc_pkg::fcc_arr_req_t ARR_REQ,
    output logic ARR_START,
    input wire logic ARR_DONE,
    input wire logic ARR_ERASED,
    output logic PUMP_EN,
    input wire logic [7:0] NV_PROT,
    input wire logic [1:0] NV_SEC,
    input wire logic KEY_MATCH,
    input wire logic STOP_REQ,
    output logic [63:0] BACKDOOR_KEY,
    output logic [6:0] FLASH_CLK_DIV,
    output logic SECURED,
    output logic IRQ
);
    import fcc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    logic wait_q;
    logic take;
    logic take_wr;
    logic wr0;
    logic [7:0] wd;
    logic [31:0] rd_mux;
    logic cfg_q;
    logic [7:0] div_q;
    logic [ADDR_W-1:0] addr_q;
    logic [63:0] key_q;
    fcc_arr_req_t buf_q;
    fcc_arr_req_t buf_d;
    fcc_seq_t seq_q;
    fcc_seq_t seq_d;
    fcc_eng_t eng_q;
    fcc_eng_t eng_d;
    logic cbef_q;
    logic cbef_d;
    logic ccf_q;
    logic ccf_d;
    logic pviol_q;
    logic pviol_d;
    logic accerr_q;
    logic accerr_d;
    logic blank_q;
    logic blank_d;
    logic [1:0] sec_q;
    logic [1:0] sec_d;
    logic pump_d;
    logic [7:0] prot_q;
    logic prot_hit;
    logic [IRQ_N-1:0] irq_set;
    logic [IRQ_N-1:0] irq_stat;
    logic [IRQ_N-1:0] irq_en;

    ////////////////////////////////////////////////////////////////////////////////
    // Every access waits exactly one cycle, which lets read data come from a flop.
    assign take = (AVS_READ || AVS_WRITE) && !wait_q;
    assign take_wr = take && AVS_WRITE;
    assign wr0 = take_wr && AVS_BYTEENABLE[0];
    assign wd = AVS_WRITEDATA[7:0];

    logic wr_cfg;
    logic wr_prot;
    logic wr_stat;
    logic wr_cmd;
    logic wr_addr_lo;
    logic wr_addr_hi;
    logic wr_data;
    logic wr_div;
    logic wr_iclr;
    logic wr_ien;
    assign wr_cfg = wr0 && (AVS_ADDRESS == REG_CONFIG);
    assign wr_prot = wr0 && (AVS_ADDRESS == REG_PROTECT);
    assign wr_stat = wr0 && (AVS_ADDRESS == REG_STATUS);
    assign wr_cmd = wr0 && (AVS_ADDRESS == REG_COMMAND);
    assign wr_addr_lo = wr0 && (AVS_ADDRESS == REG_ADDR);
    assign wr_addr_hi = take_wr && AVS_BYTEENABLE[1] && (AVS_ADDRESS == REG_ADDR);
    assign wr_data = wr0 && (AVS_ADDRESS == REG_DATA);
    assign wr_div = wr0 && (AVS_ADDRESS == REG_DIVIDER);
    assign wr_iclr = wr0 && (AVS_ADDRESS == REG_INT_CLR);
    assign wr_ien = wr0 && (AVS_ADDRESS == REG_INT_EN);

    always_comb
    begin
        rd_mux = '0;
        if (AVS_ADDRESS == REG_CONFIG)
            rd_mux[CFG_KEY_BIT] = cfg_q;
        else if (AVS_ADDRESS == REG_PROTECT)
            rd_mux[7:0] = prot_q;
        else if (AVS_ADDRESS == REG_STATUS)
            rd_mux[7:0] = {cbef_q, ccf_q, pviol_q, accerr_q, 1'b0, blank_q, 2'b00};
        else if (AVS_ADDRESS == REG_COMMAND)
            rd_mux[7:0] = buf_q.cmd;
        else if (AVS_ADDRESS == REG_ADDR)
            rd_mux[ADDR_W-1:0] = addr_q;
        else if (AVS_ADDRESS == REG_DATA)
            rd_mux[7:0] = buf_q.data;
        else if (AVS_ADDRESS == REG_DIVIDER)
            rd_mux[7:0] = div_q;
        else if (AVS_ADDRESS == REG_INT_STAT)
            rd_mux[IRQ_N-1:0] = irq_stat;
        else if (AVS_ADDRESS == REG_INT_EN)
            rd_mux[IRQ_N-1:0] = irq_en;
        else if (AVS_ADDRESS == REG_SECURITY)
            rd_mux[1:0] = sec_q;
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (!RSTN)
        begin
            wait_q <= 1'b1;
            AVS_READDATA <= '0;
        end
        else
        begin
            wait_q <= !((AVS_READ || AVS_WRITE) && wait_q);
            AVS_READDATA <= (AVS_READ && wait_q) ? rd_mux : AVS_READDATA;
        end
    end
    assign AVS_WAITREQUEST = wait_q;

    ////////////////////////////////////////////////////////////////////////////////
    logic key_wr;
    logic seq_wr;
    logic seq_err;
    logic launch_req;
    logic acc_bad;
    logic pv_bad;
    logic launch_ok;
    logic busy_ok;

    assign key_wr = wr_data && cfg_q && in_key_range(addr_q);
    assign seq_wr = wr_data && !key_wr;
    // Out-of-order steps abort the sequence so a half-built command never launches.
    assign seq_err = (seq_wr && (!cbef_q || seq_q != SEQ_IDLE))
        || (wr_cmd && seq_q != SEQ_DATA);
    assign launch_req = wr_stat && wd[ST_CBEF];
    // Behind a running command only a burst may queue, and only behind a burst.
    assign busy_ok = (eng_q == ENG_IDLE)
        || (ARR_REQ.cmd == CMD_BURST && buf_q.cmd == CMD_BURST);
    assign acc_bad = launch_req && (seq_q != SEQ_CMD || !cbef_q
        || !cmd_legal(buf_q.cmd) || !div_q[DIV_LOADED] || !busy_ok || STOP_REQ);
    assign pv_bad = launch_req && !acc_bad && cmd_modifies(buf_q.cmd) && prot_hit;
    assign launch_ok = launch_req && !acc_bad && !pv_bad;

    always_comb
    begin
        seq_d = seq_q;
        buf_d = buf_q;
        if (seq_err || launch_req)
            seq_d = SEQ_IDLE;
        else if (seq_wr)
            seq_d = SEQ_DATA;
        else if (wr_cmd)
            seq_d = SEQ_CMD;
        if (seq_wr && !seq_err)
        begin
            buf_d.addr = addr_q;
            buf_d.data = wd;
        end
        if (wr_cmd && !seq_err)
            buf_d.cmd = wd;
    end

    fcc_prot u_prot
    (
        .clk(SYS_CLK),
        .rstn(RSTN),
        .nv_copy(NV_PROT),
        .wr(wr_prot),
        .wdata(wd),
        .chk_addr(buf_q.addr),
        .chk_mass(buf_q.cmd == CMD_MASS),
        .prot_q(prot_q),
        .hit(prot_hit)
    );

    ////////////////////////////////////////////////////////////////////////////////
    logic done;
    logic retain;
    logic xfer;
    logic abort;

    assign done = (eng_q == ENG_BUSY) && ARR_DONE;
    assign retain = done && ARR_REQ.cmd == CMD_BURST && !cbef_q
        && buf_q.cmd == CMD_BURST && same_row(ARR_REQ.addr, buf_q.addr);
    assign abort = STOP_REQ && (eng_q == ENG_BUSY);
    assign xfer = !cbef_q && !abort && ((eng_q == ENG_IDLE && !STOP_REQ) || retain);

    always_comb
    begin
        eng_d = eng_q;
        pump_d = PUMP_EN;
        if (abort)
        begin
            eng_d = ENG_IDLE;
            pump_d = 1'b0;
        end
        else if (xfer)
        begin
            eng_d = ENG_BUSY;
            pump_d = cmd_modifies(buf_q.cmd);
        end
        else if (done)
        begin
            eng_d = ENG_IDLE;
            pump_d = 1'b0;
        end
    end

    // A transfer frees the buffer; a stop mid-command discards what was queued.
    assign cbef_d = (abort || xfer) ? 1'b1 : (launch_ok ? 1'b0 : cbef_q);
    assign ccf_d = cbef_d && (eng_d == ENG_IDLE);
    assign pviol_d = pv_bad || (pviol_q && !(wr_stat && wd[ST_PVIOL]));
    assign accerr_d = acc_bad || seq_err || abort
        || (accerr_q && !(wr_stat && wd[ST_ACCERR]));
    assign blank_d = launch_ok ? 1'b0
        : ((done && ARR_REQ.cmd == CMD_BLANK) ? ARR_ERASED : blank_q);
    assign sec_d = (KEY_MATCH || (done && ARR_REQ.cmd == CMD_BLANK && ARR_ERASED))
        ? SEC_UNSECURED : sec_q;

    always_ff @(posedge SYS_CLK)
    begin
        if (!RSTN)
        begin
            seq_q <= SEQ_IDLE;
            eng_q <= ENG_IDLE;
            buf_q <= '0;
            cbef_q <= 1'b1;
            ccf_q <= 1'b1;
            pviol_q <= 1'b0;
            accerr_q <= 1'b0;
            blank_q <= 1'b0;
            PUMP_EN <= 1'b0;
        end
        else
        begin
            seq_q <= seq_d;
            eng_q <= eng_d;
            buf_q <= buf_d;
            cbef_q <= cbef_d;
            ccf_q <= ccf_d;
            pviol_q <= pviol_d;
            accerr_q <= accerr_d;
            blank_q <= blank_d;
            PUMP_EN <= pump_d;
        end
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (!RSTN)
        begin
            ARR_START <= 1'b0;
            ARR_REQ <= '0;
        end
        else
        begin
            ARR_START <= xfer;
            ARR_REQ <= xfer ? buf_q : ARR_REQ;
        end
    end

    // Secure patterns are held from the nonvolatile copy, caught at reset.
    always_ff @(posedge SYS_CLK)
    begin
        if (!RSTN)
        begin
            sec_q <= NV_SEC;
            SECURED <= (NV_SEC != SEC_UNSECURED);
        end
        else
        begin
            sec_q <= sec_d;
            SECURED <= (sec_d != SEC_UNSECURED);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge SYS_CLK)
    begin
        if (!RSTN)
        begin
            cfg_q <= 1'b0;
            div_q <= '0;
            addr_q <= '0;
            key_q <= '0;
        end
        else
        begin
            cfg_q <= wr_cfg ? wd[CFG_KEY_BIT] : cfg_q;
            div_q <= wr_div ? {1'b1, wd[6:0]} : div_q;
            addr_q[7:0] <= wr_addr_lo ? wd : addr_q[7:0];
            addr_q[15:8] <= wr_addr_hi ? AVS_WRITEDATA[15:8] : addr_q[15:8];
            if (key_wr)
                key_q[{addr_q[KEY_LSB-1:0], 3'b000} +: 8] <= wd;
        end
    end
    assign BACKDOOR_KEY = key_q;
    assign FLASH_CLK_DIV = div_q[6:0];

    assign irq_set[IRQ_CCF] = ccf_d && !ccf_q;
    assign irq_set[IRQ_PVIOL] = pv_bad;
    assign irq_set[IRQ_ACCERR] = acc_bad || seq_err || abort;

    fcc_irq #(.N(IRQ_N)) u_irq
    (
        .clk(SYS_CLK),
        .rstn(RSTN),
        .set(irq_set),
        .clr_wr(wr_iclr),
        .en_wr(wr_ien),
        .wdata(wd[IRQ_N-1:0]),
        .status_q(irq_stat),
        .enable_q(irq_en),
        .irq_q(IRQ)
    );

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RSTN);

    pump_keep_a: assert property (retain && !STOP_REQ |=> PUMP_EN && ARR_START)
        else $error("pump dropped between retained bursts");
    row_match_a: assert property (ARR_START && $past(eng_q) == ENG_BUSY |->
        (ARR_REQ.addr >> ROW_LSB) == ($past(ARR_REQ.addr) >> ROW_LSB))
        else $error("retained burst left its row");
    pump_off_a: assert property (done && !retain && !abort |=> !PUMP_EN)
        else $error("pump left on after completion");
    sec_open_a: assert property (done && ARR_REQ.cmd == CMD_BLANK && ARR_ERASED
        |=> ##1 !SECURED && sec_q == SEC_UNSECURED)
        else $error("blank array did not unsecure");
    prot_hold_a: assert property (prot_q[0] |=> $stable(prot_q))
        else $error("protection changed while disabled");
    launch_clr_a: assert property (launch_ok |=> !cbef_q ##1 ARR_START || !cbef_q)
        else $error("launch did not take the buffer");
    ccf_cause_a: assert property (launch_ok |=> !ccf_q)
        else $error("complete flag not cleared by launch");
    pviol_drop_a: assert property (pv_bad |=> pviol_q && cbef_q && !ARR_START)
        else $error("protected command not discarded");
    illegal_cmd_a: assert property (launch_req && !cmd_legal(buf_q.cmd)
        |=> accerr_q && cbef_q)
        else $error("illegal command not rejected");
    blank_clr_a: assert property (launch_ok |=> !blank_q)
        else $error("blank flag survived a launch");

    burst_chain_c: cover property (retain ##1 ARR_START ##[1:50] retain);
    blank_pass_c: cover property (done && ARR_REQ.cmd == CMD_BLANK && ARR_ERASED);
    pviol_c: cover property (pv_bad);
    stop_abort_c: cover property (abort);

endmodule

// [tb/fcc_array_model.sv]
`timescale 1ns/100ps
module fcc_array_model
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic start,
    input wire logic slow,
    input wire logic blank_ok,
    output logic done,
    output logic erased
);
    logic [7:0] cnt_q;
    logic junk_q;
    // The erased line means something only with done, so it wanders in between.
    assign done = (cnt_q == 8'h01);
    assign erased = done ? blank_ok : junk_q;
    always_ff @(posedge clk)
    begin
        junk_q <= rstn ? ~junk_q : 1'b0;
        if (!rstn)
            cnt_q <= 8'h00;
        else if (start)
            cnt_q <= slow ? 8'h28 : 8'h03;
        else if (cnt_q != 8'h00)
            cnt_q <= cnt_q - 8'h01;
    end
endmodule

// [tb/flash_command_controller_tb.sv]
`timescale 1ns/100ps
module flash_command_controller_tb;
    import fcc_pkg::*;
    logic SYS_CLK = 1'b0;
    logic RSTN = 1'b0;
    logic [3:0] AVS_ADDRESS = 4'h0;
    logic AVS_READ = 1'b0;
    logic AVS_WRITE = 1'b0;
    logic [31:0] AVS_WRITEDATA = 32'h0;
    logic [31:0] AVS_READDATA;
    logic AVS_WAITREQUEST, ARR_START, ARR_DONE, ARR_ERASED, PUMP_EN, SECURED, IRQ;
    fcc_arr_req_t ARR_REQ, last_req;
    logic [7:0] NV_PROT = 8'hF0;
    logic [1:0] NV_SEC = 2'h0;
    logic KEY_MATCH = 1'b0;
    logic STOP_REQ = 1'b0;
    logic slow = 1'b0;
    logic erased_ok = 1'b1;
    logic [63:0] BACKDOOR_KEY;
    logic [6:0] FLASH_CLK_DIV;
    logic [31:0] rd;
    logic pump_at_start, pump_prev = 1'b0;
    int errors = 0, tests_run = 0, cycles = 0, starts = 0, falls = 0, s0, f0;
    int seed = 97668;
    logic [7:0] code, dat;
    logic [15:0] adr;
    logic [7:0] codes [4] = '{CMD_BLANK, CMD_PROG, CMD_BURST, CMD_PAGE};

    fcc_top u_dut (.SYS_CLK(SYS_CLK), .RSTN(RSTN), .AVS_ADDRESS(AVS_ADDRESS),
        .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
        .AVS_BYTEENABLE(4'hF), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
        .ARR_REQ(ARR_REQ), .ARR_START(ARR_START), .ARR_DONE(ARR_DONE), .ARR_ERASED(ARR_ERASED),
        .PUMP_EN(PUMP_EN), .NV_PROT(NV_PROT), .NV_SEC(NV_SEC), .KEY_MATCH(KEY_MATCH),
        .STOP_REQ(STOP_REQ), .BACKDOOR_KEY(BACKDOOR_KEY), .FLASH_CLK_DIV(FLASH_CLK_DIV),
        .SECURED(SECURED), .IRQ(IRQ));
    fcc_array_model u_array (.clk(SYS_CLK), .rstn(RSTN), .start(ARR_START), .slow(slow),
        .blank_ok(erased_ok), .done(ARR_DONE), .erased(ARR_ERASED));

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        forever #2.5 SYS_CLK = ~SYS_CLK;
    end

    // Starts and pump drops are counted here so the bus tasks never miss a pulse.
    always @(posedge SYS_CLK)
    begin
        cycles++;
        if (ARR_START === 1'b1)
        begin
            starts++;
            last_req = ARR_REQ;
            pump_at_start = PUMP_EN;
        end
        if (pump_prev === 1'b1 && PUMP_EN === 1'b0)
            falls++;
        pump_prev = PUMP_EN;
        if (cycles == 30000)
        begin
            errors++;
            give_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge SYS_CLK);
        AVS_ADDRESS <= a;
        AVS_WRITEDATA <= d;
        AVS_WRITE <= wr;
        AVS_READ <= ~wr;
        do @(posedge SYS_CLK); while (AVS_WAITREQUEST !== 1'b0);
        rd = AVS_READDATA;
        AVS_WRITE <= 1'b0;
        AVS_READ <= 1'b0;
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rdm(input logic [3:0] a, input logic [31:0] m, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(rd & m, exp);
    endtask

    task automatic issue(input logic [15:0] a, input logic [7:0] d, input logic [7:0] c);
        wr(REG_ADDR, {16'h0, a});
        wr(REG_DATA, {24'h0, d});
        wr(REG_COMMAND, {24'h0, c});
        wr(REG_STATUS, 32'h80);
    endtask

    task automatic wait_idle();
        do bus(1'b0, REG_STATUS, 32'h0); while (rd[ST_CCF] !== 1'b1);
    endtask

    task automatic do_reset(input logic [7:0] p, input logic [1:0] s);
        @(posedge SYS_CLK);
        RSTN <= 1'b0;
        NV_PROT <= p;
        NV_SEC <= s;
        repeat (16) @(posedge SYS_CLK);
        RSTN <= 1'b1;
    endtask

    function automatic logic legal(input logic [7:0] c);
        return c == CMD_BLANK || c == CMD_PROG || c == CMD_BURST || c == CMD_PAGE
            || c == CMD_MASS;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        do_reset(8'hF0, 2'h0);
        rdm(REG_STATUS, 32'hFF, 32'hC0);
        rdm(REG_PROTECT, 32'hFF, 32'hF0);
        rdm(REG_SECURITY, 32'h3, 32'h0);
        check(SECURED, 1'b1);
        issue(16'h0100, 8'h11, CMD_PROG);
        rdm(REG_STATUS, 32'h10, 32'h10);
        wr(REG_STATUS, 32'h00);
        rdm(REG_STATUS, 32'h10, 32'h10);
        wr(REG_STATUS, 32'h10);
        rdm(REG_STATUS, 32'h10, 32'h00);
        wr(REG_DIVIDER, 32'h13);
        rdm(REG_DIVIDER, 32'hFF, 32'h93);
        check(FLASH_CLK_DIV, 7'h13);
        wr(REG_COMMAND, {24'h0, CMD_PROG});
        rdm(REG_STATUS, 32'h10, 32'h10);
        wr(REG_STATUS, 32'h10);
        repeat (6)
        begin
            code = 8'($random(seed));
            if (legal(code))
                code = 8'hFF;
            issue(16'h0100, 8'h00, code);
            rdm(REG_STATUS, 32'h10, 32'h10);
            wr(REG_STATUS, 32'h10);
        end
        check(starts, 0);
        for (int i = 0; i < 4; i++)
        begin
            s0 = starts;
            adr = 16'($random(seed)) & 16'h7FFF;
            dat = 8'($random(seed));
            issue(adr, dat, codes[i]);
            wait_idle();
            check(starts, s0 + 1);
            check(last_req, {codes[i], adr, dat});
            check(pump_at_start, codes[i] != CMD_BLANK);
            check(PUMP_EN, 1'b0);
            check(rd[ST_BLANK], codes[i] == CMD_BLANK);
        end
        rdm(REG_SECURITY, 32'h3, 32'h2);
        check(SECURED, 1'b0);
        s0 = starts;
        issue(16'h0000, 8'h00, CMD_MASS);
        issue(16'hF200, 8'h00, CMD_PROG);
        rdm(REG_STATUS, 32'h20, 32'h20);
        check(starts, s0);
        wr(REG_STATUS, 32'h20);
        rdm(REG_STATUS, 32'h20, 32'h00);
        wr(REG_PROTECT, 32'h40);
        rdm(REG_PROTECT, 32'hFF, 32'h40);
        wr(REG_PROTECT, 32'h60);
        rdm(REG_PROTECT, 32'hFF, 32'h40);
        issue(16'h4200, 8'h00, CMD_PROG);
        rdm(REG_STATUS, 32'h20, 32'h20);
        wr(REG_STATUS, 32'h20);
        issue(16'h4000, 8'h5A, CMD_PROG);
        wait_idle();
        check(starts, s0 + 1);
        // Slow array so that the second burst is queued while the first runs.
        slow <= 1'b1;
        f0 = falls;
        issue(16'h1000, 8'hA1, CMD_BURST);
        issue(16'h1001, 8'hA2, CMD_BURST);
        rdm(REG_STATUS, 32'hC0, 32'h00);
        wait_idle();
        check(starts, s0 + 3);
        check(falls, f0 + 1);
        issue(16'h103F, 8'hA3, CMD_BURST);
        issue(16'h1040, 8'hA4, CMD_BURST);
        wait_idle();
        check(falls, f0 + 3);
        issue(16'h1100, 8'hB1, CMD_BURST);
        issue(16'h1101, 8'hB2, CMD_PROG);
        rdm(REG_STATUS, 32'h10, 32'h10);
        wait_idle();
        wr(REG_STATUS, 32'h10);
        issue(16'h0300, 8'h33, CMD_PROG);
        while (PUMP_EN !== 1'b1) @(posedge SYS_CLK);
        STOP_REQ <= 1'b1;
        repeat (4) @(posedge SYS_CLK);
        check(PUMP_EN, 1'b0);
        STOP_REQ <= 1'b0;
        rdm(REG_STATUS, 32'h10, 32'h10);
        wr(REG_STATUS, 32'h10);
        repeat (45) @(posedge SYS_CLK);
        slow <= 1'b0;
        s0 = starts;
        wr(REG_CONFIG, 32'h20);
        wr(REG_ADDR, 32'hFFB3);
        wr(REG_DATA, 32'hA5);
        rdm(REG_CONFIG, 32'hFF, 32'h20);
        check(BACKDOOR_KEY[31:24], 8'hA5);
        check(starts, s0);
        wr(REG_CONFIG, 32'h00);
        issue(16'hFFB0, 8'h00, CMD_PROG);
        rdm(REG_STATUS, 32'h20, 32'h20);
        wr(REG_STATUS, 32'h20);
        wr(REG_INT_CLR, 32'h7);
        rdm(REG_INT_STAT, 32'h7, 32'h0);
        wr(REG_INT_EN, 32'h1);
        issue(16'h0400, 8'h44, CMD_PROG);
        wait_idle();
        repeat (2) @(posedge SYS_CLK);
        check(IRQ, 1'b1);
        wr(REG_INT_STAT, 32'h0);
        rdm(REG_INT_STAT, 32'h7, 32'h1);
        wr(REG_INT_EN, 32'h0);
        repeat (2) @(posedge SYS_CLK);
        check(IRQ, 1'b0);
        wr(REG_INT_EN, 32'h1);
        wr(REG_INT_CLR, 32'h1);
        repeat (2) @(posedge SYS_CLK);
        check(IRQ, 1'b0);
        rdm(REG_INT_STAT, 32'h7, 32'h0);
        rdm(4'hB, 32'hFFFFFFFF, 32'h0);
        do_reset(8'hFF, 2'h1);
        rdm(REG_SECURITY, 32'h3, 32'h1);
        check(SECURED, 1'b1);
        wr(REG_DIVIDER, 32'h13);
        // A blank check over a dirty array must neither report blank nor open the part.
        erased_ok <= 1'b0;
        issue(16'h0000, 8'h00, CMD_BLANK);
        wait_idle();
        check(rd[ST_BLANK], 1'b0);
        rdm(REG_SECURITY, 32'h3, 32'h1);
        erased_ok <= 1'b1;
        wr(REG_STATUS, 32'h44);
        rdm(REG_STATUS, 32'h44, 32'h40);
        @(posedge SYS_CLK);
        KEY_MATCH <= 1'b1;
        @(posedge SYS_CLK);
        KEY_MATCH <= 1'b0;
        rdm(REG_SECURITY, 32'h3, 32'h2);
        check(SECURED, 1'b0);
        wr(REG_PROTECT, 32'h10);
        rdm(REG_PROTECT, 32'hFF, 32'hFF);
        s0 = starts;
        issue(16'h0000, 8'h00, CMD_MASS);
        wait_idle();
        check(starts, s0 + 1);
        check(last_req.cmd, 8'h41);
        give_verdict();
    end
endmodule
